//--- core/rsc_bcd_step.sv
`timescale 1ns/10ps
`default_nettype none

module rsc_bcd_step (
  input  wire logic [7:0] val_i,
  input  wire logic [6:0] lo_i,
  input  wire logic [6:0] hi_i,
  input  wire logic       inc_i,
  input  wire logic       dec_i,
  output logic      [7:0] res_o,
  output logic            wrap_o
);

  logic [6:0] bin;
  logic [6:0] nb;

  always_comb begin
    bin    = ({3'b000, val_i[7:4]} * 7'd10) + {3'b000, val_i[3:0]};
    nb     = bin;
    wrap_o = 1'b0;
    if (inc_i && !dec_i) begin
      if (bin >= hi_i) begin
        nb     = lo_i;
        wrap_o = 1'b1;
      end else begin
        nb = 7'(bin + 7'd1);
      end
    end else if (dec_i && !inc_i) begin
      if (bin <= lo_i) begin
        nb = hi_i;
      end else begin
        nb = 7'(bin - 7'd1);
      end
    end
    res_o = {4'(nb / 7'd10), 4'(nb % 7'd10)};
  end

endmodule

`default_nettype wire

//--- core/rsc_pkg.sv
package rsc_pkg;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [11:0] A_EVENT_COUNT    = 12'h000;
  localparam logic [11:0] A_CLK_DOW        = 12'h004;
  localparam logic [11:0] A_CLK_SEC        = 12'h008;
  localparam logic [11:0] A_CLK_HM         = 12'h00C;
  localparam logic [11:0] A_CLK_MD         = 12'h010;
  localparam logic [11:0] A_CLK_CY         = 12'h014;
  localparam logic [11:0] A_STAMP_SEC      = 12'h018;
  localparam logic [11:0] A_STAMP_HM       = 12'h01C;
  localparam logic [11:0] A_STAMP_MD       = 12'h020;
  localparam logic [11:0] A_STAMP_CY       = 12'h024;
  localparam logic [11:0] A_STAMP_WD_CAUSE = 12'h028;
  localparam logic [11:0] A_ADJUST         = 12'h02C;
  localparam logic [11:0] A_CONTROL        = 12'h030;
  localparam logic [11:0] A_TERM_TX        = 12'h040;
  localparam logic [11:0] A_TERM_RX        = 12'h044;
  localparam logic [11:0] A_CARD_TX        = 12'h048;
  localparam logic [11:0] A_CARD_RX        = 12'h04C;
  localparam logic [11:0] A_TEL_SENT       = 12'h050;
  localparam logic [11:0] A_TEL_RECV       = 12'h054;
  localparam logic [11:0] A_TEL_REFUSED    = 12'h058;

  // ----------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------
  localparam int F_DOW  = 0;
  localparam int F_SEC  = 1;
  localparam int F_MIN  = 2;
  localparam int F_HOUR = 3;
  localparam int F_DAY  = 4;
  localparam int F_MON  = 5;
  localparam int F_YEAR = 6;
  localparam int F_CENT = 7;
  localparam int NUM_FIELDS   = 8;
  localparam int NUM_COUNTERS = 8;
  localparam int CTRL_UNLOCK  = 0;
  localparam int CTRL_ADJ_EN  = 1;
  localparam int ADJ_DEC_BASE = 8;

  // binary bounds per field, index order as above
  localparam logic [NUM_FIELDS-1:0][6:0] FIELD_LO =
    {7'd0, 7'd0, 7'd1, 7'd1, 7'd0, 7'd0, 7'd0, 7'd1};
  localparam logic [NUM_FIELDS-1:0][6:0] FIELD_HI =
    {7'd99, 7'd99, 7'd12, 7'd31, 7'd23, 7'd59, 7'd59, 7'd7};

  // reset date: monday 2000-01-01 00:00:00 (bcd)
  localparam logic [NUM_FIELDS-1:0][7:0] CLOCK_RESET =
    {8'h20, 8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h01};

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam longint SECOND_NS    = 64'd1_000_000_000;
  localparam longint CLK_PERIOD_NS = 64'd10;
  localparam longint SECOND_CYCLES = SECOND_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } rsc_apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } rsc_apb_rsp_type;

  // one-cycle pulses from the controller; order = counter index
  typedef struct packed {
    logic tel_refused;
    logic tel_recv;
    logic tel_sent;
    logic card_rx;
    logic card_tx;
    logic term_rx;
    logic term_tx;
    logic event_done;
  } rsc_evt_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_DONE = 2'b10
  } rsc_bus_st_type;

  typedef struct packed {
    rsc_bus_st_type                   st;
    rsc_apb_rsp_type                  rsp;
    logic [NUM_FIELDS-1:0][7:0]       clk_f;
    logic [NUM_FIELDS-1:0][7:0]       stamp;
    logic [7:0]                       cause;
    logic [15:0]                      adjust;
    logic [15:0]                      adjust_prev;
    logic                             unlock;
    logic                             adj_en;
    logic [NUM_COUNTERS-1:0][15:0]    cnt;
    logic [31:0]                      presc;
  } rsc_state_type;

endpackage

//--- core/rsc_rtc_top.sv
`timescale 1ns/10ps
`default_nettype none

module rsc_rtc_top
  import rsc_pkg::*;
#(
  parameter longint SEC_CYCLES = SECOND_CYCLES
) (
  input  wire logic            mclk_i,
  input  wire logic            rst_b_i,
  input  wire rsc_apb_req_type apb_i,
  output rsc_apb_rsp_type      apb_o,
  input  wire rsc_evt_type     evt_i,
  input  wire logic            cold_start_i,
  input  wire logic            stop_i,
  input  wire logic [7:0]      stop_cause_i
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (SEC_CYCLES < 1 || SEC_CYCLES > 64'h0000_0000_FFFF_FFFF) begin : g_chk
    $error("SEC_CYCLES out of range");
  end

  localparam logic [31:0] SEC_LAST = 32'(SEC_CYCLES - 1);

  rsc_state_type r_reg;
  rsc_state_type r_next;

  logic [NUM_FIELDS-1:0]      car;
  logic [NUM_FIELDS-1:0]      wr;
  logic [NUM_FIELDS-1:0]      inc;
  logic [NUM_FIELDS-1:0]      dec;
  logic [NUM_FIELDS-1:0][7:0] stepped;
  logic [NUM_FIELDS-1:0][6:0] hi_v;
  logic [15:0]                rise;
  logic                       tick;
  logic [6:0]                 dim;

  // ----------------------------------------------------------------
  // days in month with leap years
  // ----------------------------------------------------------------
  function automatic logic [6:0] days_in_month(
    input logic [7:0] mon,
    input logic [7:0] yr,
    input logic [7:0] cen
  );
    logic [6:0] yb;
    logic [6:0] cb;
    logic       leap;
    yb   = ({3'b000, yr[7:4]} * 7'd10) + {3'b000, yr[3:0]};
    cb   = ({3'b000, cen[7:4]} * 7'd10) + {3'b000, cen[3:0]};
    leap = (yb == 7'd0) ? (cb[1:0] == 2'b00) : (yb[1:0] == 2'b00);
    case (mon)
      8'h02:   days_in_month = leap ? 7'd29 : 7'd28;
      8'h04,
      8'h06,
      8'h09,
      8'h11:   days_in_month = 7'd30;
      default: days_in_month = 7'd31;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // field stepping
  // ----------------------------------------------------------------
  assign tick = (r_reg.presc == SEC_LAST) && !r_reg.unlock;
  assign dim  = days_in_month(r_reg.clk_f[F_MON], r_reg.clk_f[F_YEAR],
                              r_reg.clk_f[F_CENT]);

  // rising edges of adjust bits, gated by enable
  assign rise = r_reg.adjust & ~r_reg.adjust_prev & {16{r_reg.adj_en}};

  // carry chain sec -> min -> hour -> day/weekday -> month -> year -> century
  assign car[F_SEC]  = tick;
  assign car[F_MIN]  = car[F_SEC] & wr[F_SEC];
  assign car[F_HOUR] = car[F_MIN] & wr[F_MIN];
  assign car[F_DAY]  = car[F_HOUR] & wr[F_HOUR];
  assign car[F_DOW]  = car[F_DAY];
  assign car[F_MON]  = car[F_DAY] & wr[F_DAY];
  assign car[F_YEAR] = car[F_MON] & wr[F_MON];
  assign car[F_CENT] = car[F_YEAR] & wr[F_YEAR];

  generate
    for (genvar f = 0; f < NUM_FIELDS; f++) begin : g_field
      // bit f increments, bit f+8 decrements, field f in weekday..century order
      assign inc[f]  = car[f] | rise[f];
      assign dec[f]  = rise[f + ADJ_DEC_BASE];
      assign hi_v[f] = (f == F_DAY) ? dim : FIELD_HI[f];

      rsc_bcd_step u_step (
        .val_i  (r_reg.clk_f[f]),
        .lo_i   (FIELD_LO[f]),
        .hi_i   (hi_v[f]),
        .inc_i  (inc[f]),
        .dec_i  (dec[f]),
        .res_o  (stepped[f]),
        .wrap_o (wr[f])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [31:0] rd;
    logic        hit;
    logic [11:0] a;
    logic [31:0] wd;
    rd     = 32'h0000_0000;
    hit    = 1'b1;
    a      = apb_i.paddr;
    wd     = apb_i.pwdata;
    r_next = r_reg;

    // prescaler and clock fields
    r_next.presc = (r_reg.presc == SEC_LAST) ? 32'h0000_0000
                                             : 32'(r_reg.presc + 32'd1);
    r_next.clk_f       = stepped;
    r_next.adjust_prev = r_reg.adjust;

    // snapshot on fault or stop
    if (stop_i) begin
      r_next.stamp = r_reg.clk_f;
      r_next.cause = stop_cause_i;
    end

    // counters
    for (int i = 0; i < NUM_COUNTERS; i++) begin
      if (cold_start_i) begin
        r_next.cnt[i] = 16'h0000;
      end else if (evt_i[i]) begin
        r_next.cnt[i] = 16'(r_reg.cnt[i] + 16'd1);
      end
    end

    // read mux and address decode
    if (a == A_EVENT_COUNT) begin
      rd = {16'h0000, r_reg.cnt[0]};
    end else if (a == A_CLK_DOW) begin
      rd = {24'h00_0000, r_reg.clk_f[F_DOW]};
    end else if (a == A_CLK_SEC) begin
      rd = {16'h0000, r_reg.clk_f[F_SEC], 8'h00};
    end else if (a == A_CLK_HM) begin
      rd = {16'h0000, r_reg.clk_f[F_HOUR], r_reg.clk_f[F_MIN]};
    end else if (a == A_CLK_MD) begin
      rd = {16'h0000, r_reg.clk_f[F_MON], r_reg.clk_f[F_DAY]};
    end else if (a == A_CLK_CY) begin
      rd = {16'h0000, r_reg.clk_f[F_CENT], r_reg.clk_f[F_YEAR]};
    end else if (a == A_STAMP_SEC) begin
      rd = {24'h00_0000, r_reg.stamp[F_SEC]};
    end else if (a == A_STAMP_HM) begin
      rd = {16'h0000, r_reg.stamp[F_HOUR], r_reg.stamp[F_MIN]};
    end else if (a == A_STAMP_MD) begin
      rd = {16'h0000, r_reg.stamp[F_MON], r_reg.stamp[F_DAY]};
    end else if (a == A_STAMP_CY) begin
      rd = {16'h0000, r_reg.stamp[F_CENT], r_reg.stamp[F_YEAR]};
    end else if (a == A_STAMP_WD_CAUSE) begin
      rd = {16'h0000, r_reg.stamp[F_DOW], r_reg.cause};
    end else if (a == A_ADJUST) begin
      rd = {16'h0000, r_reg.adjust};
    end else if (a == A_CONTROL) begin
      rd = {16'h0000, 14'h0000, r_reg.adj_en, r_reg.unlock};
    end else if (a == A_TERM_TX) begin
      rd = {16'h0000, r_reg.cnt[1]};
    end else if (a == A_TERM_RX) begin
      rd = {16'h0000, r_reg.cnt[2]};
    end else if (a == A_CARD_TX) begin
      rd = {16'h0000, r_reg.cnt[3]};
    end else if (a == A_CARD_RX) begin
      rd = {16'h0000, r_reg.cnt[4]};
    end else if (a == A_TEL_SENT) begin
      rd = {16'h0000, r_reg.cnt[5]};
    end else if (a == A_TEL_RECV) begin
      rd = {16'h0000, r_reg.cnt[6]};
    end else if (a == A_TEL_REFUSED) begin
      rd = {16'h0000, r_reg.cnt[7]};
    end else begin
      hit = 1'b0;
    end

    // ----------------------------------------------------------------
    // apb slave
    // ----------------------------------------------------------------
    case (r_reg.st)
      ST_IDLE: begin
        if (apb_i.psel && apb_i.penable) begin
          r_next.rsp.pready  = 1'b1;
          r_next.rsp.pslverr = !hit;
          r_next.rsp.prdata  = apb_i.pwrite ? 32'h0000_0000 : rd;
          r_next.st          = ST_DONE;
        end
      end
      ST_DONE: begin
        r_next.rsp.pready  = 1'b0;
        r_next.rsp.pslverr = 1'b0;
        r_next.st          = ST_IDLE;
        // write commits on the edge where the master sees pready high
        if (apb_i.psel && apb_i.penable && apb_i.pwrite && hit) begin
          if (a == A_ADJUST) begin
            r_next.adjust = wd[15:0];
          end else if (a == A_CONTROL) begin
            r_next.unlock = wd[CTRL_UNLOCK];
            r_next.adj_en = wd[CTRL_ADJ_EN];
          end else if (r_reg.unlock) begin
            // user write replaces the clock value only while unlocked
            if (a == A_CLK_DOW) begin
              r_next.clk_f[F_DOW] = wd[7:0];
            end else if (a == A_CLK_SEC) begin
              r_next.clk_f[F_SEC] = wd[15:8];
            end else if (a == A_CLK_HM) begin
              r_next.clk_f[F_HOUR] = wd[15:8];
              r_next.clk_f[F_MIN]  = wd[7:0];
            end else if (a == A_CLK_MD) begin
              r_next.clk_f[F_MON] = wd[15:8];
              r_next.clk_f[F_DAY] = wd[7:0];
            end else if (a == A_CLK_CY) begin
              r_next.clk_f[F_CENT] = wd[15:8];
              r_next.clk_f[F_YEAR] = wd[7:0];
            end
          end
        end
      end
      default: begin
        r_next.st          = ST_IDLE;
        r_next.rsp.pready  = 1'b0;
        r_next.rsp.pslverr = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      r_reg             <= '0;
      r_reg.st          <= ST_IDLE;
      r_reg.clk_f       <= CLOCK_RESET;
      r_reg.stamp       <= CLOCK_RESET;
    end else begin
      r_reg <= r_next;
    end
  end

  assign apb_o = r_reg.rsp;

endmodule

`default_nettype wire

//--- verif/rsc_rtc_sva.sv
`timescale 1ns/10ps
`default_nettype none

module rsc_rtc_sva
  import rsc_pkg::*;
(
  input wire logic            mclk_i,
  input wire logic            rst_b_i,
  input wire rsc_apb_req_type apb_i,
  input wire rsc_apb_rsp_type apb_o,
  input wire rsc_evt_type     evt_i,
  input wire logic            cold_start_i,
  input wire logic            stop_i,
  input wire logic [7:0]      stop_cause_i
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_b_i);

  logic        rd_ok;
  logic [11:0] a;
  logic [31:0] d;
  assign rd_ok = apb_o.pready && !apb_i.pwrite;
  assign a     = apb_i.paddr;
  assign d     = apb_o.prdata;

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  AST_ANSWER: assert property ($rose(apb_i.penable) && apb_i.psel |=> apb_o.pready ##1 !apb_o.pready)
    else $error("pready is not a single pulse after access");
  AST_DOW_RANGE: assert property (rd_ok && a == A_CLK_DOW |-> d inside {[32'h0000_0001:32'h0000_0007]})
    else $error("weekday word out of range");
  AST_SEC_WORD: assert property (rd_ok && a == A_CLK_SEC |-> d[7:0] == 8'h00 && d[15:8] <= 8'h59)
    else $error("seconds word malformed");
  AST_HM_WORD: assert property (rd_ok && a == A_CLK_HM |-> d[15:8] <= 8'h23 && d[7:0] <= 8'h59)
    else $error("hours minutes word out of range");
  AST_MD_WORD: assert property (rd_ok && a == A_CLK_MD |-> d[15:8] inside {[8'h01:8'h12]} && d[7:0] inside {[8'h01:8'h31]})
    else $error("month day word out of range");
  AST_STAMP_SEC: assert property (rd_ok && a == A_STAMP_SEC |-> d[31:8] == 24'h00_0000)
    else $error("stamp seconds upper byte not zero");
  AST_STAMP_DOW: assert property (rd_ok && a == A_STAMP_WD_CAUSE |-> d[15:8] inside {[8'h01:8'h07]})
    else $error("stamp weekday out of range");
  AST_COLD_CLEAR: assert property (cold_start_i && $past(cold_start_i) && apb_i.psel && apb_i.penable
    && !apb_i.pwrite && !apb_o.pready && a == A_EVENT_COUNT |=> d == 32'h0000_0000)
    else $error("event count not clear during cold start");
  AST_CNT_WIDTH: assert property (rd_ok && a >= A_TERM_TX |-> d[31:16] == 16'h0000)
    else $error("counter wider than sixteen bits");
  AST_MAPPED_OK: assert property (apb_o.pready && a <= A_CONTROL && a[1:0] == 2'b00 |-> !apb_o.pslverr)
    else $error("error response on a mapped word");

  COV_ERR: cover property (apb_o.pslverr);
  COV_CAUSE: cover property (rd_ok && a == A_STAMP_WD_CAUSE);
  COV_COLD: cover property (cold_start_i && rd_ok && a == A_EVENT_COUNT);
endmodule

`default_nettype wire

//--- verif/rsc_rtc_test.sv
`timescale 1ns/10ps
`default_nettype none

module rsc_rtc_test
  import rsc_pkg::*;
;
  logic            mclk_i   = 1'b0;
  logic            rst_b_i  = 1'b0;
  rsc_apb_req_type req      = '0;
  rsc_apb_rsp_type rsp;
  rsc_evt_type     evt      = '0;
  logic            cold     = 1'b0;
  logic            stop     = 1'b0;
  logic [7:0]      cause    = 8'h00;
  int              failures = 0;
  int              checked  = 0;
  logic [31:0]     rd;
  logic            err;
  logic [11:0]     cnt_a [8] = '{A_EVENT_COUNT, A_TERM_TX, A_TERM_RX, A_CARD_TX, A_CARD_RX,
                                 A_TEL_SENT, A_TEL_RECV, A_TEL_REFUSED};
  logic [7:0]      codes [5] = '{8'h01, 8'h02, 8'h04, 8'h05, 8'h06};

  rsc_rtc_top #(.SEC_CYCLES(20)) dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .apb_i(req),
    .apb_o(rsp), .evt_i(evt), .cold_start_i(cold), .stop_i(stop), .stop_cause_i(cause));

  initial begin
    forever #5 mclk_i = ~mclk_i;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic end_of_test();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int n = 0;
    req.psel    <= 1'b1;
    req.pwrite  <= w;
    req.paddr   <= a;
    req.pwdata  <= wd;
    @(posedge mclk_i);
    req.penable <= 1'b1;
    @(posedge mclk_i);
    while (rsp.pready !== 1'b1) begin
      n++;
      if (n > 20) begin
        failures++;
        end_of_test();
      end
      @(posedge mclk_i);
    end
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
    @(posedge mclk_i);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] wd);
    xfer(1'b1, a, wd);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask

  task automatic pulse(input rsc_evt_type m);
    evt <= m;
    @(posedge mclk_i);
    evt <= '0;
    @(posedge mclk_i);
  endtask

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    @(posedge mclk_i);
    rdc(A_CLK_DOW, 32'h0000_0001);
    rdc(A_CLK_MD, 32'h0000_0101);
    rdc(A_CLK_CY, 32'h0000_2000);
    xfer(1'b0, 12'h034, 32'h0000_0000);
    chk({31'h0, err}, 32'h0000_0001);
    chk(rd, 32'h0000_0000);
    $display("reset test done");
    wr(A_CONTROL, 32'h0000_0001);
    wr(A_CLK_SEC, 32'h0000_5900);
    wr(A_CLK_HM, 32'h0000_2359);
    wr(A_CLK_MD, 32'h0000_1231);
    wr(A_CLK_CY, 32'h0000_1999);
    rdc(A_CLK_MD, 32'h0000_1231);
    wr(A_CONTROL, 32'h0000_0000);
    xfer(1'b0, A_CLK_SEC, 32'h0000_0000);
    for (int i = 0; i < 20 && rd === 32'h0000_5900; i++) begin
      xfer(1'b0, A_CLK_SEC, 32'h0000_0000);
    end
    chk(rd, 32'h0000_0000);
    rdc(A_CLK_HM, 32'h0000_0000);
    rdc(A_CLK_MD, 32'h0000_0101);
    rdc(A_CLK_CY, 32'h0000_2000);
    wr(A_CLK_HM, 32'h0000_1234);
    rdc(A_CLK_HM, 32'h0000_0000);
    $display("tick test done");
    wr(A_CONTROL, 32'h0000_0001);
    wr(A_CLK_SEC, 32'h0000_0000);
    wr(A_ADJUST, 32'h0000_00FF);
    rdc(A_CLK_HM, 32'h0000_0000);
    wr(A_ADJUST, 32'h0000_0000);
    wr(A_CONTROL, 32'h0000_0003);
    rdc(A_CONTROL, 32'h0000_0003);
    wr(A_ADJUST, 32'h0000_00FF);
    wr(A_ADJUST, 32'h0000_00FF);
    rdc(A_CLK_DOW, 32'h0000_0003);
    rdc(A_CLK_SEC, 32'h0000_0100);
    rdc(A_CLK_HM, 32'h0000_0101);
    rdc(A_CLK_MD, 32'h0000_0202);
    rdc(A_CLK_CY, 32'h0000_2101);
    wr(A_ADJUST, 32'h0000_FF00);
    rdc(A_CLK_DOW, 32'h0000_0002);
    rdc(A_CLK_MD, 32'h0000_0101);
    rdc(A_CLK_CY, 32'h0000_2000);
    wr(A_ADJUST, 32'h0000_0000);
    wr(A_ADJUST, 32'h0000_0C00);
    rdc(A_CLK_HM, 32'h0000_2359);
    rdc(A_ADJUST, 32'h0000_0C00);
    wr(A_CLK_DOW, 32'h0000_0007);
    rdc(A_CLK_DOW, 32'h0000_0007);
    wr(A_ADJUST, 32'h0000_0C01);
    rdc(A_CLK_DOW, 32'h0000_0001);
    $display("adjust test done");
    wr(A_CLK_SEC, 32'h0000_4200);
    foreach (codes[i]) begin
      cause <= codes[i];
      stop  <= 1'b1;
      @(posedge mclk_i);
      stop  <= 1'b0;
      @(posedge mclk_i);
      rdc(A_STAMP_WD_CAUSE, {16'h0000, 8'h01, codes[i]});
    end
    rdc(A_STAMP_SEC, 32'h0000_0042);
    rdc(A_STAMP_CY, 32'h0000_2000);
    rdc(A_STAMP_MD, 32'h0000_0101);
    wr(A_STAMP_HM, 32'h0000_FFFF);
    rdc(A_STAMP_HM, 32'h0000_2359);
    $display("stop test done");
    for (int i = 0; i < 8; i++) begin
      repeat (i + 1) pulse(rsc_evt_type'(8'h01 << i));
    end
    for (int i = 0; i < 8; i++) begin
      rdc(cnt_a[i], 32'(i + 1));
    end
    cold <= 1'b1;
    @(posedge mclk_i);
    rdc(A_EVENT_COUNT, 32'h0000_0000);
    cold <= 1'b0;
    foreach (cnt_a[i]) begin
      rdc(cnt_a[i], 32'h0000_0000);
    end
    $display("counter test done");
    end_of_test();
  end
endmodule

bind rsc_rtc_top rsc_rtc_sva u_sva (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .apb_i(apb_i),
  .apb_o(apb_o), .evt_i(evt_i), .cold_start_i(cold_start_i), .stop_i(stop_i),
  .stop_cause_i(stop_cause_i));

`default_nettype wire
